// *** bench/cpu_core_model.sv ***
// ****************************************
// processor side of the register bus
// ****************************************
module cpu_core_model (
	input wire logic core_clk,
	output logic io_instruction,
	output logic [7:0] bus_addr,
	output logic bus_write,
	output logic bus_read,
	output logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		io_instruction = 1'b0;
		bus_addr = 8'h00;
		bus_write = 1'b0;
		bus_read = 1'b0;
		bus_wdata = 8'h00;
	end
	// one strobe held across the taking edge; released lines show inverse
	// io accesses stay below 0x40, extended ones use data addresses
	task automatic access(input logic io, input logic [7:0] a,
			input logic wr, input logic [7:0] d);
		@(negedge core_clk);
		io_instruction = io;
		bus_addr = a;
		bus_wdata = d;
		bus_write = wr;
		bus_read = !wr;
		@(negedge core_clk);
		bus_write = 1'b0;
		bus_read = 1'b0;
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask
	task automatic write_byte(input logic io, input logic [7:0] a,
			input logic [7:0] d);
		access(io, a, 1'b1, d);
	endtask
	task automatic read_byte(input logic io, input logic [7:0] a,
			output logic [7:0] d);
		access(io, a, 1'b0, 8'h00);
		@(negedge core_clk);
		d = bus_rdata;
	endtask
	// word write high byte first, into the shared latch
	task automatic write_word(input logic [7:0] a, input logic [15:0] v);
		write_byte(1'b0, a + 8'h01, v[15:8]);
		write_byte(1'b0, a, v[7:0]);
	endtask
endmodule

// *** bench/test_timer16_capture_compare_regs.sv ***
// ****************************************
// register, capture and interrupt tests
// ****************************************
module test_timer16_capture_compare_regs;
	import timer_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst_n = 1'b0, io_instruction, bus_write, bus_read;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, timer_interrupt_mask;
	logic [15:0] counter1_value = 16'h0001, counter3_value = 16'h0000;
	logic [15:0] compare1a_value = 16'hFFF0, compare1b_value = 16'hFFF1;
	logic counter1_overflow = 1'b0, wrap_sets_flag1 = 1'b1;
	logic top_from_capture1 = 1'b0, top_from_capture3 = 1'b0;
	logic forced_match_strobe = 1'b0, capture_input_pin1 = 1'b0;
	logic capture_input_pin3 = 1'b1, comparator_out = 1'b0;
	logic capture1_from_comparator = 1'b0, capture1_rising = 1'b1;
	logic capture3_rising = 1'b0, global_irq_enable = 1'b0;
	logic capture1_serviced = 1'b0, match1a_serviced = 1'b0;
	logic match1b_serviced = 1'b0, wrap1_serviced = 1'b0;
	logic irq_capture1, irq_match1a, irq_match1b, irq_wrap1;
	logic capture1_is_top, capture3_is_top;
	logic [15:0] capture1_value, capture3_value;
	logic [15:0] compare3a_value, compare3b_value, compare3c_value;
	int n_errors = 0, num_checks = 0, cycles = 0;
	logic [7:0] reg_addr [11] = '{8'h46, 8'h47, 8'h56, 8'h57, 8'h80,
		8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h87};
	timer16_capture_compare_regs i_timer16_capture_compare_regs (.*);
	cpu_core_model i_cpu_core_model (
		.core_clk(core_clk),
		.io_instruction(io_instruction),
		.bus_addr(bus_addr),
		.bus_write(bus_write),
		.bus_read(bus_read),
		.bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata)
	);
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic io, input logic [7:0] a,
			input logic [7:0] d);
		i_cpu_core_model.write_byte(io, a, d);
	endtask
	task automatic rd(input logic io, input logic [7:0] a,
			input logic [7:0] exp);
		logic [7:0] d;
		i_cpu_core_model.read_byte(io, a, d);
		check({8'h00, d}, {8'h00, exp});
	endtask
	function automatic logic [3:0] irqs();
		return {irq_capture1, irq_match1a, irq_match1b, irq_wrap1};
	endfunction
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		// ****************************************
		// reset values
		// ****************************************
		foreach (reg_addr[k])
			rd(1'b0, reg_addr[k], 8'h00);
		$display("test reset done");
		// ****************************************
		// address windows and word registers
		// ****************************************
		wr(1'b1, 8'h37, 8'hA5);
		rd(1'b0, 8'h57, 8'hA5);
		check({8'h00, timer_interrupt_mask}, 16'h00A5);
		wr(1'b0, 8'h17, 8'hFF);
		rd(1'b1, 8'h37, 8'hA5);
		for (int k = 0; k < 3; k++)
			i_cpu_core_model.write_word(8'h82 + 8'(2 * k), 16'hC3C0 + 16'(k));
		wr(1'b1, 8'h06, 8'h77);
		check(compare3c_value, 16'hC3C0);
		check(compare3b_value, 16'hC3C1);
		check(compare3a_value, 16'hC3C2);
		rd(1'b0, 8'h84, 8'hC1);
		wr(1'b0, 8'h83, 8'h5A);
		wr(1'b0, 8'h84, 8'h3C);
		check(compare3b_value, 16'h5A3C);
		check(compare3c_value, 16'hC3C0);
		$display("test windows done");
		// ****************************************
		// capture loads and coherent reads
		// ****************************************
		counter1_value = 16'h1234;
		capture_input_pin1 = 1'b1;
		cyc(8);
		check(capture1_value, 16'h1234);
		rd(1'b0, 8'h56, 8'h20);
		rd(1'b1, 8'h26, 8'h34);
		counter1_value = 16'hBEEF;
		capture_input_pin1 = 1'b0;
		cyc(8);
		capture_input_pin1 = 1'b1;
		cyc(8);
		check(capture1_value, 16'hBEEF);
		rd(1'b1, 8'h27, 8'h12);
		counter3_value = 16'h4321;
		capture_input_pin3 = 1'b0;
		cyc(8);
		check(capture3_value, 16'h4321);
		rd(1'b0, 8'h80, 8'h21);
		rd(1'b0, 8'h81, 8'h43);
		capture1_from_comparator = 1'b1;
		counter1_value = 16'h0A0B;
		capture_input_pin1 = 1'b0;
		cyc(8);
		capture_input_pin1 = 1'b1;
		cyc(8);
		check(capture1_value, 16'hBEEF);
		comparator_out = 1'b1;
		cyc(8);
		check(capture1_value, 16'h0A0B);
		counter1_value = 16'h0001;
		top_from_capture1 = 1'b1;
		top_from_capture3 = 1'b1;
		wr(1'b0, 8'h56, 8'hFF);
		cyc(2);
		check({14'h0000, capture1_is_top, capture3_is_top}, 16'h0003);
		$display("test capture done");
		// ****************************************
		// flags and interrupt requests
		// ****************************************
		wr(1'b1, 8'h37, 8'h3C);
		global_irq_enable = 1'b1;
		for (int k = 0; k < 4; k++) begin
			case (k)
				0: counter1_value = 16'h0A0B;
				1: compare1a_value = counter1_value;
				2: compare1b_value = counter1_value;
				default: counter1_overflow = 1'b1;
			endcase
			@(negedge core_clk);
			counter1_value = 16'h0001;
			compare1a_value = 16'hFFF0;
			compare1b_value = 16'hFFF1;
			counter1_overflow = 1'b0;
			cyc(4);
			check({12'h000, irqs()}, 16'h0008 >> k);
			rd(1'b0, 8'h56, 8'h20 >> k);
			if (k[0]) begin
				wr(1'b1, 8'h36, 8'h20 >> k);
			end else begin
				{capture1_serviced, match1a_serviced} = 2'(k == 0 ? 2 : 1);
				{match1b_serviced, wrap1_serviced} = 2'(k == 2 ? 2 : 0);
				@(negedge core_clk);
				{capture1_serviced, match1a_serviced} = 2'b00;
				{match1b_serviced, wrap1_serviced} = 2'b00;
			end
			cyc(3);
			check({12'h000, irqs()}, 16'h0000);
			rd(1'b0, 8'h56, 8'h00);
		end
		global_irq_enable = 1'b0;
		counter1_overflow = 1'b1;
		@(negedge core_clk);
		counter1_overflow = 1'b0;
		cyc(4);
		check({15'h0000, irq_wrap1}, 16'h0000);
		global_irq_enable = 1'b1;
		wr(1'b0, 8'h57, 8'h00);
		cyc(3);
		check({15'h0000, irq_wrap1}, 16'h0000);
		wr(1'b0, 8'h57, 8'h04);
		cyc(3);
		check({15'h0000, irq_wrap1}, 16'h0001);
		wr(1'b0, 8'h56, 8'h04);
		wrap_sets_flag1 = 1'b0;
		counter1_overflow = 1'b1;
		forced_match_strobe = 1'b1;
		@(negedge core_clk);
		counter1_overflow = 1'b0;
		forced_match_strobe = 1'b0;
		cyc(4);
		rd(1'b0, 8'h56, 8'h00);
		$display("test interrupts done");
		final_report();
	end
endmodule

// *** logic/capture_word.sv ***
module capture_word
	import timer_regs_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic capture_load,
	input wire logic [WIDTH-1:0] counter_value,
	input wire logic write_en,
	input wire logic [WIDTH-1:0] write_value,
	output logic [WIDTH-1:0] value
);
	logic [WIDTH-1:0] next_value;

	// ****************************************
	// capture beats a software write
	// ****************************************
	always_comb begin
		next_value = value;
		if (capture_load) begin
			next_value = counter_value;
		end else if (write_en) begin
			next_value = write_value;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= WORD_RESET[WIDTH-1:0];
		end else begin
			value <= next_value;
		end
	end
endmodule

// *** logic/pin_event_sync.sv ***
module pin_event_sync
	import timer_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic rising_sel,
	output logic event_pulse
);
	logic [SYNC_STAGES-1:0] stage;
	logic level;
	logic next_level;
	logic next_event;

	// ****************************************
	// filtered level: stages two and three agree
	// ****************************************
	always_comb begin
		next_level = level;
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
		next_event = (next_level != level) && (next_level == rising_sel);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= '0;
			level <= 1'b0;
			event_pulse <= 1'b0;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], pin};
			level <= next_level;
			event_pulse <= next_event;
		end
	end
endmodule

// *** logic/timer16_capture_compare_regs.sv ***
module timer16_capture_compare_regs
	import timer_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic io_instruction,
	input wire logic [7:0] bus_addr,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [15:0] counter1_value,
	input wire logic [15:0] counter3_value,
	input wire logic [15:0] compare1a_value,
	input wire logic [15:0] compare1b_value,
	input wire logic counter1_overflow,
	input wire logic wrap_sets_flag1,
	input wire logic top_from_capture1,
	input wire logic top_from_capture3,
	input wire logic forced_match_strobe,
	input wire logic capture_input_pin1,
	input wire logic capture_input_pin3,
	input wire logic comparator_out,
	input wire logic capture1_from_comparator,
	input wire logic capture1_rising,
	input wire logic capture3_rising,
	input wire logic global_irq_enable,
	input wire logic capture1_serviced,
	input wire logic match1a_serviced,
	input wire logic match1b_serviced,
	input wire logic wrap1_serviced,
	output logic irq_capture1,
	output logic irq_match1a,
	output logic irq_match1b,
	output logic irq_wrap1,
	output logic [7:0] timer_interrupt_mask,
	output logic capture1_is_top,
	output logic capture3_is_top,
	output logic [15:0] capture1_value,
	output logic [15:0] capture3_value,
	output logic [15:0] compare3a_value,
	output logic [15:0] compare3b_value,
	output logic [15:0] compare3c_value
);
	// ****************************************
	// capture sources
	// ****************************************
	logic [2:0] raw_source;
	logic [2:0] edge_sel;
	logic [2:0] source_event;
	logic [1:0] capture_load;
	logic [15:0] capture_word_value [2];
	logic [1:0] capture_write;
	logic [15:0] counter_pick [2];
	logic [7:0] high_latch;

	assign raw_source = {comparator_out, capture_input_pin3,
		capture_input_pin1};
	assign edge_sel = {capture1_rising, capture3_rising, capture1_rising};
	assign counter_pick[0] = counter1_value;
	assign counter_pick[1] = counter3_value;
	assign capture_load[0] = capture1_from_comparator ? source_event[2] :
		source_event[0];
	assign capture_load[1] = source_event[1];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			pin_event_sync u_sync (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.pin(raw_source[gi]),
				.rising_sel(edge_sel[gi]),
				.event_pulse(source_event[gi])
			);
		end
		for (gi = 0; gi < 2; gi++) begin : g_cap
			capture_word #(.WIDTH(16)) u_cap (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.capture_load(capture_load[gi]),
				.counter_value(counter_pick[gi]),
				.write_en(capture_write[gi]),
				.write_value({high_latch, bus_wdata}),
				.value(capture_word_value[gi])
			);
		end
	endgenerate

	// ****************************************
	// address decode
	// ****************************************
	logic [7:0] reg_offset;
	logic offset_valid;

	always_comb begin
		reg_offset = bus_addr;
		offset_valid = 1'b1;
		if (io_instruction) begin
			reg_offset = {2'b00, bus_addr[IO_WINDOW_BITS-1:0]};
		end else if (bus_addr >= EXTENDED_IO_START) begin
			reg_offset = bus_addr;
		end else if (bus_addr >= IO_SPACE_OFFSET) begin
			reg_offset = bus_addr - IO_SPACE_OFFSET;
		end else begin
			offset_valid = 1'b0;
		end
	end

	// ****************************************
	// register file and shared latch
	// ****************************************
	logic [7:0] next_high_latch;
	logic [7:0] next_mask;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [15:0] next_c3a;
	logic [15:0] next_c3b;
	logic [15:0] next_c3c;
	logic [7:0] next_rdata;
	logic [7:0] flag_byte;
	logic wr;
	logic rd;
	logic match1a_now;
	logic match1b_now;
	logic top1_reached;

	assign wr = bus_write && offset_valid;
	assign rd = bus_read && offset_valid;
	assign match1a_now = counter1_value == compare1a_value;
	assign match1b_now = counter1_value == compare1b_value;
	assign top1_reached = top_from_capture1 &&
		counter1_value == capture_word_value[0];
	assign capture_write[0] = wr && reg_offset == CAPTURE1_LOW_OFFSET;
	assign capture_write[1] = wr && reg_offset == CAPTURE3_LOW_OFFSET;

	always_comb begin
		flag_byte = BYTE_RESET;
		flag_byte[CAPTURE1_BIT] = flags[3];
		flag_byte[MATCH1A_BIT] = flags[2];
		flag_byte[MATCH1B_BIT] = flags[1];
		flag_byte[WRAP1_BIT] = flags[0];
	end

	always_comb begin
		next_high_latch = high_latch;
		next_mask = timer_interrupt_mask;
		next_c3a = compare3a_value;
		next_c3b = compare3b_value;
		next_c3c = compare3c_value;
		next_rdata = bus_rdata;
		next_flags = flags;
		if (wr) begin
			unique case (reg_offset)
				CAPTURE1_HIGH_OFFSET, CAPTURE3_HIGH_OFFSET,
				COMPARE3A_HIGH_OFFSET, COMPARE3B_HIGH_OFFSET,
				COMPARE3C_HIGH_OFFSET: begin
					next_high_latch = bus_wdata;
				end
				COMPARE3A_LOW_OFFSET: begin
					next_c3a = {high_latch, bus_wdata};
				end
				COMPARE3B_LOW_OFFSET: begin
					next_c3b = {high_latch, bus_wdata};
				end
				COMPARE3C_LOW_OFFSET: begin
					next_c3c = {high_latch, bus_wdata};
				end
				INTERRUPT_MASK_OFFSET: begin
					next_mask = bus_wdata;
				end
				EVENT_FLAGS_OFFSET: begin
					next_flags = flags & ~{bus_wdata[CAPTURE1_BIT],
						bus_wdata[MATCH1A_BIT], bus_wdata[MATCH1B_BIT],
						bus_wdata[WRAP1_BIT]};
				end
				default: begin
				end
			endcase
		end
		// service clears, hardware set wins last
		if (capture1_serviced) next_flags[3] = 1'b0;
		if (match1a_serviced) next_flags[2] = 1'b0;
		if (match1b_serviced) next_flags[1] = 1'b0;
		if (wrap1_serviced) next_flags[0] = 1'b0;
		if (capture_load[0] || top1_reached) next_flags[3] = 1'b1;
		if (match1a_now) next_flags[2] = 1'b1;
		if (match1b_now) next_flags[1] = 1'b1;
		if (counter1_overflow && wrap_sets_flag1) begin
			next_flags[0] = 1'b1;
		end
		if (rd) begin
			next_rdata = BYTE_RESET;
			unique case (reg_offset)
				CAPTURE1_LOW_OFFSET: begin
					next_rdata = capture_word_value[0][7:0];
					next_high_latch = capture_word_value[0][15:8];
				end
				CAPTURE3_LOW_OFFSET: begin
					next_rdata = capture_word_value[1][7:0];
					next_high_latch = capture_word_value[1][15:8];
				end
				COMPARE3A_LOW_OFFSET: begin
					next_rdata = compare3a_value[7:0];
					next_high_latch = compare3a_value[15:8];
				end
				COMPARE3B_LOW_OFFSET: begin
					next_rdata = compare3b_value[7:0];
					next_high_latch = compare3b_value[15:8];
				end
				COMPARE3C_LOW_OFFSET: begin
					next_rdata = compare3c_value[7:0];
					next_high_latch = compare3c_value[15:8];
				end
				CAPTURE1_HIGH_OFFSET, CAPTURE3_HIGH_OFFSET,
				COMPARE3A_HIGH_OFFSET, COMPARE3B_HIGH_OFFSET,
				COMPARE3C_HIGH_OFFSET: begin
					next_rdata = high_latch;
				end
				INTERRUPT_MASK_OFFSET: begin
					next_rdata = timer_interrupt_mask;
				end
				EVENT_FLAGS_OFFSET: begin
					next_rdata = flag_byte;
				end
				default: begin
					next_rdata = BYTE_RESET;
				end
			endcase
		end
	end

	// forced strobe deliberately feeds no flag
	logic unused_forced;
	assign unused_forced = forced_match_strobe;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_latch <= BYTE_RESET;
			timer_interrupt_mask <= BYTE_RESET;
			flags <= 4'h0;
			compare3a_value <= WORD_RESET;
			compare3b_value <= WORD_RESET;
			compare3c_value <= WORD_RESET;
			bus_rdata <= BYTE_RESET;
		end else begin
			high_latch <= next_high_latch;
			timer_interrupt_mask <= next_mask;
			flags <= next_flags;
			compare3a_value <= next_c3a;
			compare3b_value <= next_c3b;
			compare3c_value <= next_c3c;
			bus_rdata <= next_rdata;
		end
	end

	// ****************************************
	// interrupt requests and outputs
	// ****************************************
	logic next_irq_c;
	logic next_irq_a;
	logic next_irq_b;
	logic next_irq_w;

	always_comb begin
		next_irq_c = timer_interrupt_mask[CAPTURE1_BIT] && global_irq_enable
			&& flags[3];
		next_irq_a = timer_interrupt_mask[MATCH1A_BIT] && global_irq_enable
			&& flags[2];
		next_irq_b = timer_interrupt_mask[MATCH1B_BIT] && global_irq_enable
			&& flags[1];
		next_irq_w = timer_interrupt_mask[WRAP1_BIT] && global_irq_enable
			&& flags[0];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_capture1 <= 1'b0;
			irq_match1a <= 1'b0;
			irq_match1b <= 1'b0;
			irq_wrap1 <= 1'b0;
			capture1_is_top <= 1'b0;
			capture3_is_top <= 1'b0;
			capture1_value <= WORD_RESET;
			capture3_value <= WORD_RESET;
		end else begin
			irq_capture1 <= next_irq_c;
			irq_match1a <= next_irq_a;
			irq_match1b <= next_irq_b;
			irq_wrap1 <= next_irq_w;
			capture1_is_top <= top_from_capture1;
			capture3_is_top <= top_from_capture3;
			capture1_value <= capture_word_value[0];
			capture3_value <= capture_word_value[1];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_capture_loads: assert property (capture_load[0] |=>
		capture_word_value[0] == $past(counter1_value))
		else $error("capture did not load counter");
	a_comparator_source: assert property (
		capture1_from_comparator && source_event[2] |-> capture_load[0])
		else $error("comparator event not used");
	a_latch_on_low: assert property (rd && !wr &&
		reg_offset == CAPTURE1_LOW_OFFSET |=>
		high_latch == $past(capture_word_value[0][15:8]))
		else $error("high byte not latched");
	a_high_from_latch: assert property (rd &&
		reg_offset == CAPTURE3_HIGH_OFFSET |=>
		bus_rdata == $past(high_latch))
		else $error("high read not from latch");
	a_data_space: assert property (!io_instruction &&
		bus_addr == CAPTURE1_LOW_OFFSET + IO_SPACE_OFFSET |->
		reg_offset == CAPTURE1_LOW_OFFSET)
		else $error("data space offset wrong");
	a_irq_capture: assert property (irq_capture1 ==
		$past(timer_interrupt_mask[CAPTURE1_BIT] && global_irq_enable
		&& flags[3]))
		else $error("capture irq wrong");
	a_irq_match_a: assert property (irq_match1a |->
		$past(flags[2] && global_irq_enable))
		else $error("match a irq without cause");
	a_irq_match_b: assert property (!global_irq_enable |=> !irq_match1b)
		else $error("match b irq while disabled");
	a_irq_wrap: assert property (irq_wrap1 |-> $past(flags[0]))
		else $error("wrap irq without flag");
	a_service_clear: assert property (capture1_serviced && !capture_load[0]
		&& !top1_reached |=> !flags[3])
		else $error("capture flag not cleared");
	a_match_sets: assert property (match1a_now |=> flags[2])
		else $error("match a flag not set");
	a_wrap_sets: assert property (counter1_overflow && wrap_sets_flag1
		|=> flags[0])
		else $error("wrap flag not set");
	a_mask_kept: assert property (!(wr &&
		reg_offset == INTERRUPT_MASK_OFFSET) |=> $stable(timer_interrupt_mask))
		else $error("mask changed");

	c_capture_event: cover property (capture_load[0] ##1 irq_capture1);
	c_coherent_read: cover property (rd && reg_offset == CAPTURE1_LOW_OFFSET
		##[1:4] rd && reg_offset == CAPTURE1_HIGH_OFFSET);
	c_comparator: cover property (capture1_from_comparator && capture_load[0]);
endmodule

// *** logic/timer_regs_pkg.sv ***
package timer_regs_pkg;
	// ****************************************
	// address windows
	// ****************************************
	localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
	localparam logic [7:0] EXTENDED_IO_START = 8'h60;
	localparam int IO_WINDOW_BITS = 6;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] CAPTURE1_LOW_OFFSET = 8'h26;
	localparam logic [7:0] CAPTURE1_HIGH_OFFSET = 8'h27;
	localparam logic [7:0] EVENT_FLAGS_OFFSET = 8'h36;
	localparam logic [7:0] INTERRUPT_MASK_OFFSET = 8'h37;
	localparam logic [7:0] CAPTURE3_LOW_OFFSET = 8'h80;
	localparam logic [7:0] CAPTURE3_HIGH_OFFSET = 8'h81;
	localparam logic [7:0] COMPARE3C_LOW_OFFSET = 8'h82;
	localparam logic [7:0] COMPARE3C_HIGH_OFFSET = 8'h83;
	localparam logic [7:0] COMPARE3B_LOW_OFFSET = 8'h84;
	localparam logic [7:0] COMPARE3B_HIGH_OFFSET = 8'h85;
	localparam logic [7:0] COMPARE3A_LOW_OFFSET = 8'h86;
	localparam logic [7:0] COMPARE3A_HIGH_OFFSET = 8'h87;
	// ****************************************
	// bit positions in mask and flag registers
	// ****************************************
	localparam int CAPTURE1_BIT = 5;
	localparam int MATCH1A_BIT = 4;
	localparam int MATCH1B_BIT = 3;
	localparam int WRAP1_BIT = 2;
	// ****************************************
	// reset values and synchronizer depth
	// ****************************************
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int SYNC_STAGES = 3;
endpackage
